// >>> hw/rsq_pkg.sv
// Package for the register sequencer command interpreter: opcodes, fields, state codes
package rsq_pkg;
   // Command word layout
   localparam int unsigned OPC_HI = 31;
   localparam int unsigned OPC_LO = 28;
   localparam int unsigned OAN_BIT = 27;
   localparam int unsigned INV_BIT = 26;
   localparam int unsigned EVT_HI = 25;
   localparam int unsigned EVT_W = 26;
   localparam int unsigned SEC_W = 11;
   localparam int unsigned TASKS = 2;
   localparam int unsigned ADDR_STEP = 4;
   // Opcodes
   localparam logic [3:0] OP_CLR = 4'h0;
   localparam logic [3:0] OP_SET = 4'h1;
   localparam logic [3:0] OP_PAUSE = 4'h2;
   localparam logic [3:0] OP_LATE = 4'h3;
   localparam logic [3:0] OP_UPLD = 4'h4;
   localparam logic [3:0] OP_STOP = 4'h5;
   localparam logic [3:0] OP_IRQ = 4'h6;
   localparam logic [3:0] OP_JUMP = 4'h8;
   // Upper event bits all usable
   // Event mask: bit 7 unused, never counts as selected
   localparam logic [25:0] EVT_VALID = 26'h3FF_FF7F;
   // Upload section mask: bit 7 reserved
   localparam logic [10:0] SEC_VALID = 11'h77F;
   // Reset values
   localparam logic [31:0] PTR_RST = 32'h0000_0000;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
   localparam logic [25:0] EVT_ZERO = 26'h000_0000;
   // Sequencer state codes, one-hot
   typedef enum logic [4:0] {
      ST_IDLE = 5'b0_0001,
      ST_FETCH = 5'b0_0010,
      ST_EXEC = 5'b0_0100,
      ST_WAIT = 5'b0_1000,
      ST_JADDR = 5'b1_0000
   } rsq_state_t;
endpackage

// >>> hw/rsq_fetch_if.sv
// Fetch request and answer group between the top and one task engine
`timescale 1ns/1ps
interface rsq_fetch_if;
   logic req;
   logic [31:0] addr;
   logic ack;
   logic [31:0] data;
   modport task_mp (output req, output addr, input ack, input data);
   modport top_mp (input req, input addr, output ack, output data);
endinterface : rsq_fetch_if

// >>> hw/rsq_task.sv
// One sequencer task engine: fetch, decode, wait, and execute commands
`timescale 1ns/1ps
module rsq_task
   import rsq_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic start_i,
   input wire logic [31:0] start_addr_i,
   input wire logic [31:0] timeout_i,
   input wire logic [25:0] evt_i,
   input wire logic vsync_i,
   input wire logic to_vsync_i,
   rsq_fetch_if.task_mp fetch,
   output logic enable_o,
   output logic [31:0] pointer_o,
   output logic to_pulse_o,
   output logic late_pulse_o,
   output logic irq_pulse_o,
   output logic upld_pulse_o,
   output logic [10:0] upld_sec_o,
   output logic set_pulse_o,
   output logic clr_pulse_o,
   output logic [25:0] sig_sel_o
);
   rsq_state_t state_ff;
   logic [31:0] cmd_ff;
   logic [31:0] to_cnt_ff;
   logic upld_after_ff;   // Late-check ends in an upload
   logic [25:0] sel;
   logic [25:0] hit;
   logic cond;
   logic none;
   logic tick;
   assign sel = cmd_ff[EVT_HI:0] & EVT_VALID;
   assign hit = evt_i & sel;
   assign none = (sel == EVT_ZERO);
   assign cond = (cmd_ff[OAN_BIT] ? (hit != EVT_ZERO) : (hit == sel)) ^ cmd_ff[INV_BIT];
   assign tick = to_vsync_i ? vsync_i : 1'b1;
   assign fetch.req = (state_ff == ST_FETCH) || (state_ff == ST_JADDR);
   assign fetch.addr = pointer_o;

   // Command sequencing
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_ff <= ST_IDLE;
         cmd_ff <= ZERO32;
         pointer_o <= PTR_RST;
         enable_o <= 1'b0;
         upld_after_ff <= 1'b0;
         to_cnt_ff <= ZERO32;
      end else if (ce_i) begin
         case (state_ff)
            ST_IDLE: begin
               if (start_i) begin
                  pointer_o <= start_addr_i;
                  enable_o <= 1'b1;
                  state_ff <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               if (fetch.ack) begin
                  cmd_ff <= fetch.data;
                  pointer_o <= pointer_o + ADDR_STEP;
                  state_ff <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               to_cnt_ff <= timeout_i;
               upld_after_ff <= 1'b0;
               case (cmd_ff[OPC_HI:OPC_LO])
                  OP_PAUSE: state_ff <= cond ? ST_FETCH : ST_WAIT;
                  OP_LATE: begin
                     if (cond) begin
                        state_ff <= ST_FETCH;
                     end else begin
                        upld_after_ff <= 1'b1;
                        state_ff <= ST_WAIT;
                     end
                  end
                  OP_STOP: begin
                     if (cond || none) begin
                        enable_o <= 1'b0;
                        state_ff <= ST_IDLE;
                     end else begin
                        state_ff <= ST_FETCH;
                     end
                  end
                  OP_JUMP: state_ff <= ST_JADDR;
                  default: state_ff <= ST_FETCH;
               endcase
            end
            ST_WAIT: begin
               if (cond) begin
                  state_ff <= ST_FETCH;
               end else if (tick) begin
                  if (to_cnt_ff == ZERO32) begin
                     enable_o <= 1'b0;
                     state_ff <= ST_IDLE;
                  end else begin
                     to_cnt_ff <= to_cnt_ff - 32'h0000_0001;
                  end
               end
            end
            ST_JADDR: begin
               if (fetch.ack) begin
                  pointer_o <= (cond || none) ? fetch.data : pointer_o + ADDR_STEP;
                  state_ff <= ST_FETCH;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // One-cycle event pulses to the top
   always_comb begin
      to_pulse_o = 1'b0;
      late_pulse_o = 1'b0;
      irq_pulse_o = 1'b0;
      upld_pulse_o = 1'b0;
      set_pulse_o = 1'b0;
      clr_pulse_o = 1'b0;
      upld_sec_o = cmd_ff[SEC_W-1:0] & SEC_VALID;
      sig_sel_o = sel;
      if (ce_i && state_ff == ST_EXEC) begin
         case (cmd_ff[OPC_HI:OPC_LO])
            OP_CLR: clr_pulse_o = 1'b1;
            OP_SET: set_pulse_o = 1'b1;
            OP_UPLD: upld_pulse_o = 1'b1;
            OP_LATE: late_pulse_o = cond;
            OP_IRQ: irq_pulse_o = cond;
            default: irq_pulse_o = 1'b0;
         endcase
      end else if (ce_i && state_ff == ST_WAIT && !cond && tick && to_cnt_ff == ZERO32) begin
         to_pulse_o = 1'b1;
      end else if (ce_i && state_ff == ST_WAIT && cond && upld_after_ff) begin
         upld_pulse_o = 1'b1;
      end
   end
endmodule // rsq_task

// >>> hw/rsq_top.sv
// Register sequencer command interpreter top: two tasks, fetch arbiter, flags
`timescale 1ns/1ps
module rsq_top
   import rsq_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // Task control
   input wire logic [1:0] sequencer_task_start_i,
   input wire logic [31:0] start_addr0_i,
   input wire logic [31:0] start_addr1_i,
   input wire logic [31:0] timeout0_i,
   input wire logic [31:0] timeout1_i,
   input wire logic [1:0] timeout_vsync_i,
   input wire logic vsync_i,
   output logic [1:0] sequencer_task_enable_o,
   output logic [31:0] sequencer_command_pointer0_o,
   output logic [31:0] sequencer_command_pointer1_o,
   // Raw status events (real status bits)
   input wire logic [25:0] primary_status_word_i,
   // Task flags, cleared by writing ones, and the private event copy
   input wire logic [1:0] flag_clear_i,
   output logic [1:0] sequencer_timeout_flag_o,
   output logic [1:0] sequencer_late_flag_o,
   output logic [1:0] sequencer_irq_flag_o,
   output logic [25:0] event_copy_o,
   // Upload strobe to the shadow block
   output logic upload_o,
   output logic [10:0] upload_sections_o,
   // Memory fetch port
   output logic mem_req_o,
   output logic [31:0] mem_addr_o,
   input wire logic mem_ack_i,
   input wire logic [31:0] mem_data_i
);
   logic [25:0] prev_ff;   // Last raw status, for rising and falling edges
   logic [25:0] rise;
   logic [25:0] fall;
   logic [1:0] to_p, late_p, irq_p, up_p, set_p, clr_p;
   logic [10:0] sec [TASKS];
   logic [25:0] ssel [TASKS];
   logic [31:0] ptr [TASKS];
   logic [1:0] en;
   logic [1:0] req;
   logic [1:0] grant;
   logic owner_ff;         // Task holding the memory port
   logic busy_ff;

   rsq_fetch_if fif [TASKS] ();

   // One engine per task
   for (genvar t = 0; t < TASKS; t++) begin : g_task
      rsq_task u_task (
         .clk_i(clk_i),
         .reset_i(reset_i),
         .ce_i(ce_i),
         .start_i(sequencer_task_start_i[t]),
         .start_addr_i(t == 0 ? start_addr0_i : start_addr1_i),
         .timeout_i(t == 0 ? timeout0_i : timeout1_i),
         .evt_i(event_copy_o),
         .vsync_i(vsync_i),
         .to_vsync_i(timeout_vsync_i[t]),
         .fetch(fif[t]),
         .enable_o(en[t]),
         .pointer_o(ptr[t]),
         .to_pulse_o(to_p[t]),
         .late_pulse_o(late_p[t]),
         .irq_pulse_o(irq_p[t]),
         .upld_pulse_o(up_p[t]),
         .upld_sec_o(sec[t]),
         .set_pulse_o(set_p[t]),
         .clr_pulse_o(clr_p[t]),
         .sig_sel_o(ssel[t])
      );
      assign req[t] = fif[t].req;
      assign fif[t].ack = mem_ack_i && grant[t];
      assign fif[t].data = mem_data_i;
   end

   assign sequencer_task_enable_o = en;
   assign sequencer_command_pointer0_o = ptr[0];
   assign sequencer_command_pointer1_o = ptr[1];

   // Fetch arbiter: owner held until ack, task 0 wins a tie
   assign grant[0] = busy_ff ? !owner_ff : req[0];
   assign grant[1] = busy_ff ? owner_ff : (req[1] && !req[0]);
   assign mem_req_o = |req;
   assign mem_addr_o = grant[1] ? fif[1].addr : fif[0].addr;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         busy_ff <= 1'b0;
         owner_ff <= 1'b0;
      end else if (ce_i) begin
         if (mem_ack_i) begin
            busy_ff <= 1'b0;
         end else if (!busy_ff && |req) begin
            busy_ff <= 1'b1;
            owner_ff <= !req[0];
         end
      end
   end

   assign rise = primary_status_word_i & ~prev_ff;
   assign fall = ~primary_status_word_i & prev_ff;

   // Private event copies: edges follow status, a set beats a fall, a rise beats a clear
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         prev_ff <= EVT_ZERO;
         event_copy_o <= EVT_ZERO;
      end else if (ce_i) begin
         prev_ff <= primary_status_word_i;
         // Private copy only; real rise wins over clear
         event_copy_o <= ((event_copy_o & ~fall
                          & ~(clr_p[0] ? ssel[0] : EVT_ZERO)
                          & ~(clr_p[1] ? ssel[1] : EVT_ZERO))
                          | (set_p[0] ? ssel[0] : EVT_ZERO)
                          | (set_p[1] ? ssel[1] : EVT_ZERO)
                          | rise) & EVT_VALID;
      end
   end

   // Sticky task flags: a new event wins over a clear
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sequencer_timeout_flag_o <= 2'h0;
         sequencer_late_flag_o <= 2'h0;
         sequencer_irq_flag_o <= 2'h0;
      end else if (ce_i) begin
         sequencer_timeout_flag_o <= (sequencer_timeout_flag_o & ~flag_clear_i) | to_p;
         sequencer_late_flag_o <= (sequencer_late_flag_o & ~flag_clear_i) | late_p;
         sequencer_irq_flag_o <= (sequencer_irq_flag_o & ~flag_clear_i) | irq_p;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         upload_o <= 1'b0;
         upload_sections_o <= 11'h000;
      end else if (ce_i) begin
         upload_o <= |up_p;
         upload_sections_o <= (up_p[0] ? sec[0] : 11'h000) | (up_p[1] ? sec[1] : 11'h000);
      end
   end
endmodule // rsq_top

// >>> bench/rsq_top_checker.sv
// Port-level assertions for the sequencer command interpreter
`timescale 1ns/1ps
module rsq_top_checker (
   // Clock, reset and control
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic [1:0] sequencer_task_start_i,
   input wire logic [25:0] primary_status_word_i,
   input wire logic [1:0] flag_clear_i,
   // Observed state
   input wire logic [1:0] sequencer_task_enable_o,
   input wire logic [1:0] sequencer_timeout_flag_o,
   input wire logic [1:0] sequencer_irq_flag_o,
   input wire logic [25:0] event_copy_o,
   input wire logic upload_o,
   input wire logic [10:0] upload_sections_o,
   // Fetch port
   input wire logic mem_req_o,
   input wire logic [31:0] mem_addr_o,
   input wire logic mem_ack_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   req_hold_a: assert property (mem_req_o && !(mem_ack_i && ce_i)
      |=> mem_req_o && $stable(mem_addr_o)) else $error("fetch request dropped");
   idle_noreq_a: assert property (sequencer_task_enable_o == 2'b00
      |-> !mem_req_o) else $error("fetch while both tasks idle");
   timeout_stop_a: assert property ($rose(sequencer_timeout_flag_o[0])
      |-> ##[0:1] !sequencer_task_enable_o[0]) else $error("task runs on after time-out");
   irq_sticky_a: assert property (sequencer_irq_flag_o[0] && !flag_clear_i[0]
      |=> sequencer_irq_flag_o[0]) else $error("interrupt flag lost");
   irq_run_a: assert property ($rose(sequencer_irq_flag_o[0])
      |-> $past(sequencer_task_enable_o[0])) else $error("interrupt flag from idle task");
   start_enable_a: assert property ($rose(sequencer_task_enable_o[0])
      |-> $past(sequencer_task_start_i[0])) else $error("task enabled without start");
   upload_sec_a: assert property (upload_o
      |-> !upload_sections_o[7]) else $error("reserved section uploaded");
   event_rise_a: assert property ($rose(primary_status_word_i[0])
      |-> ##[1:2] event_copy_o[0]) else $error("event copy missed a rising edge");
   cover property ($rose(sequencer_timeout_flag_o[0]));
   cover property (upload_o);
   cover property ($rose(sequencer_irq_flag_o[0]));
endmodule // rsq_top_checker

// >>> bench/rsq_mem_model.sv
// Host memory model holding command lists and answering fetches
`timescale 1ns/1ps
module rsq_mem_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Fetch port
   input wire logic req_i,
   input wire logic [31:0] addr_i,
   input wire logic slow_i,
   output logic ack_o,
   output logic [31:0] data_o
);
   logic [31:0] mem [0:63]; // Command words by word address
   logic [1:0] wait_ff; // Cycles still to stall
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ack_o <= 1'b0;
         data_o <= 32'h0000_0000;
         wait_ff <= 2'h0;
      end else begin
         ack_o <= 1'b0;
         // Data bus toggles between answers: the last word and its inverse alternate
         data_o <= ~data_o;
         if (req_i && !ack_o) begin
            if (wait_ff == 2'h0) begin
               ack_o <= 1'b1;
               data_o <= mem[addr_i[7:2]];
               wait_ff <= slow_i ? 2'h2 : 2'h0;
            end else begin
               wait_ff <= wait_ff - 2'h1;
            end
         end
      end
   end
endmodule // rsq_mem_model

// >>> bench/rsq_top_bench.sv
// Self-checking bench for the sequencer command interpreter
`timescale 1ns/1ps
module rsq_top_bench;
   import rsq_pkg::*;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic vs = 1'b0;
   logic c = 1'b0;
   logic ce = 1'b1;
   logic [1:0] st = 2'b00;
   logic [1:0] clr = 2'b00;
   logic [31:0] to0 = 32'h0000_0005;
   logic [31:0] w = 32'h0000_0000;
   logic [25:0] raw = 26'h000_0000;
   logic [1:0] en, tof, late, irq;
   logic [31:0] p0, p1, ma, md;
   logic [25:0] cp;
   logic [10:0] sec, got_sec;
   logic upl, req, ack;
   int num_errors = 0;
   int comparisons = 0;
   int seed = 11;
   int cyc = 0;
   int nu = 0;
   int k;
   always #10 clk_i = ~clk_i;
   rsq_top DUT (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce),
      .sequencer_task_start_i(st), .start_addr0_i(32'h0000_0000),
      .start_addr1_i(32'h0000_0040), .timeout0_i(to0), .timeout1_i(32'h0000_0005),
      .timeout_vsync_i(2'b00), .vsync_i(vs), .sequencer_task_enable_o(en),
      .sequencer_command_pointer0_o(p0), .sequencer_command_pointer1_o(p1),
      .primary_status_word_i(raw), .flag_clear_i(clr), .sequencer_timeout_flag_o(tof),
      .sequencer_late_flag_o(late), .sequencer_irq_flag_o(irq), .event_copy_o(cp),
      .upload_o(upl), .upload_sections_o(sec), .mem_req_o(req), .mem_addr_o(ma),
      .mem_ack_i(ack), .mem_data_i(md));
   rsq_mem_model MEM (.clk_i(clk_i), .reset_i(reset_i), .req_i(req), .addr_i(ma),
      .slow_i(w[0]), .ack_o(ack), .data_o(md));
   // Expected condition; bit 7 is never selected
   function automatic logic cond(input logic [31:0] cw, input logic [25:0] ev);
      logic [25:0] s;
      s = cw[25:0] & EVT_VALID;
      return (cw[27] ? |(ev & s) : ((ev & s) == s)) ^ cw[26];
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      if (got !== exp)
         num_errors++;
   endtask
   task automatic ld(input int a, input logic [31:0] d);
      MEM.mem[a / 4] = d;
   endtask
   // Start tasks, then wait a bounded time for them to stop
   task automatic go(input logic [1:0] which);
      int n;
      @(negedge clk_i);
      st = which;
      @(negedge clk_i);
      st = 2'b00;
      for (n = 0; n < 300 && en !== 2'b00; n++)
         @(negedge clk_i);
      if (n == 300)
         num_errors++;
   endtask
   task automatic fl();
      @(negedge clk_i);
      clr = 2'b11;
      @(negedge clk_i);
      clr = 2'b00;
   endtask
   task automatic settle(input logic [25:0] v);
      raw = v;
      repeat (3) @(negedge clk_i);
   endtask
   task automatic rise();
      repeat (8) @(negedge clk_i);
      raw[21] = 1'b1;
   endtask
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Frame tick, upload monitor and hang guard
   always @(negedge clk_i) vs = ~vs;
   // Sampled on the falling edge so registered pulses have settled
   always @(negedge clk_i) begin
      cyc++;
      if (upl === 1'b1) begin
         nu++;
         got_sec = sec;
      end
      if (cyc == 20000) begin
         num_errors++;
         conclude();
      end
   end
   initial begin
      repeat (6) @(negedge clk_i);
      reset_i = 1'b0;
      // NOP, then jump; task 1 shares the port
      ld(0, 32'h0000_0000);
      ld(4, 32'h8000_0000);
      ld(8, 32'h0000_0040);
      ld(64, 32'h5000_0000);
      go(2'b11);
      chk(p0, 32'h0000_0044);
      chk(p1, 32'h0000_0044);
      $display("test straight done");
      for (int i = 0; i < 12; i++) begin
         w = $random(seed);
         w[31:28] = OP_IRQ;
         if (i == 0)
            w[27:0] = 28'h000_0000;
         settle(26'($random(seed)));
         c = cond(w, raw);
         ld(0, w);
         ld(4, {OP_JUMP, w[27:0]});
         ld(8, 32'h0000_0080);
         ld(12, 32'h5000_0000);
         ld(128, 32'h5000_0000);
         go(2'b01);
         chk(irq, {31'h0, c});
         chk(p0, (c || (w[25:0] & EVT_VALID) == 26'h0) ? 32'h0000_0084 : 32'h0000_0010);
         fl();
      end
      $display("test conditions done");
      settle(26'h000_0000);
      ld(0, {OP_PAUSE, 28'h020_0000});
      ld(4, 32'h5000_0000);
      go(2'b01);
      chk(tof, 32'h0000_0001);
      chk(p0, 32'h0000_0004);
      fl();
      to0 = 32'h0000_0040;
      fork
         go(2'b01);
         rise();
      join
      chk(tof, 32'h0000_0000);
      chk(p0, 32'h0000_0008);
      k = nu;
      ld(0, {OP_LATE, 28'h020_0000});
      go(2'b01);
      chk(late, 32'h0000_0001);
      chk(nu - k, 0);
      fl();
      settle(26'h000_0000);
      k = nu;
      fork
         go(2'b01);
         rise();
      join
      chk(late, 32'h0000_0000);
      chk(nu - k, 1);
      $display("test waits done");
      k = nu;
      ld(0, {OP_UPLD, 28'h000_07FF});
      go(2'b01);
      chk(nu - k, 1);
      chk(got_sec, 32'h0000_077F);
      settle(26'h000_0000);
      ld(0, {OP_SET, 28'h020_0000});
      go(2'b01);
      chk(cp[21], 1);
      ld(0, {OP_CLR, 28'h020_0000});
      go(2'b01);
      chk(cp[21], 0);
      settle(26'h020_0000);
      chk(cp[21], 1);
      $display("test signals done");
      // Frozen block ignores a start
      @(negedge clk_i);
      ce = 1'b0;
      st = 2'b01;
      repeat (3) @(negedge clk_i);
      st = 2'b00;
      chk(en, 32'h0000_0000);
      ce = 1'b1;
      $display("test freeze done");
      conclude();
   end
endmodule // rsq_top_bench
bind rsq_top rsq_top_checker CHK (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
   .sequencer_task_start_i(sequencer_task_start_i), .flag_clear_i(flag_clear_i),
   .primary_status_word_i(primary_status_word_i), .event_copy_o(event_copy_o),
   .sequencer_task_enable_o(sequencer_task_enable_o), .upload_o(upload_o),
   .sequencer_timeout_flag_o(sequencer_timeout_flag_o), .mem_req_o(mem_req_o),
   .sequencer_irq_flag_o(sequencer_irq_flag_o), .upload_sections_o(upload_sections_o),
   .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i));
